// ===== rtl/wake_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz aclk; all wake timing counted in 1 us ticks
// Notes: Times are in microseconds and double as tick counts
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define NS_PER_US 1000
`define TICK_CYC (`NS_PER_US / `CLK_PERIOD_NS)
`define WU_MIN_US 9'h042
`define WU_MAX_US 9'h05f
`define WU_LOW_US 9'h0c8
`define WU_SETUP_US 9'h050
`define WU_PULSE_US 9'h055
`define WU_ON_US 9'h002
`define WU_HIZ_US 9'h1a2
// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_W 5
`define OFS_CTRL 5'h00
`define OFS_INT 5'h04
`define OFS_MASK 5'h08
`define OFS_STAT 5'h0c
`define CTRL_REQ 0
`define CTRL_CURRENT_LIMIT_DISABLE 1
`define CTRL_LVL 2
`define CTRL_TXEN 3
`define INT_WAKE 0
`define INT_DONE 1
`define CTRL_RST 4'h0
`define MASK_RST 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/wake_pkg.sv
// Purpose: Types shared by the wake-up block
// Assumes: One-hot state codes
// Notes: Constants live in wake_map.svh
package wake_pkg;
  typedef enum logic [4:0] {
    G_IDLE  = 5'h01,
    G_SETUP = 5'h02,
    G_PULSE = 5'h04,
    G_ON    = 5'h08,
    G_HIZ   = 5'h10
  } gen_state_t;
  typedef enum logic [2:0] {
    D_WAIT  = 3'h1,
    D_PULSE = 3'h2,
    D_LONG  = 3'h4
  } det_state_t;
  typedef struct packed {
    logic out;
    logic oe;
  } cq_drive_t;
  typedef struct packed {
    logic wake_active;
    logic limit_off;
  } cur_limit_t;
endpackage

// ===== rtl/cq_wakeup_detect_generate.sv
// Purpose: Wake-up detection and generation on the C/Q line
// Assumes: aclk 50 MHz, aresetn synchronous active low, AXI4-Lite registers
// Notes: Line levels and the mode strap are pins, synchronised here
//
// What this block does
// - Reject wake pulses shorter than minimum width
// - Reject wake pulses longer than maximum width
// - Valid wake drives wake output low 200us
// - Serial mode only; hold level 80us first
// - Drive opposite-polarity pulse, at most 85us
// - Then drive original polarity about 2us
// - Then release driver for 418us, done
// - Wake request forces 500mA limit regardless
// - Pin mode: data/wake pin asserts on wake
// - Serial: pulse irq pin if masked, none pending
// - Serial unmasked: set flag, hold till read
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "wake_map.svh"
module cq_wakeup_detect_generate import wake_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [`ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Line and pins
  input wire logic cq_in,
  input wire logic serial_mode_pin,
  output cq_drive_t cq_drive,
  output cur_limit_t cur_limit,
  output logic data_wake_pin_n,
  output logic wake_irq_pin_n,
  output logic irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] reg_sel(input logic [`ADDR_W-1:0] a);
    reg_sel = {a == `OFS_STAT, a == `OFS_MASK, a == `OFS_INT, a == `OFS_CTRL};
  endfunction
  function automatic logic at_end(input logic [8:0] c, input logic [8:0] lim);
    at_end = (c == lim - 9'h001);
  endfunction

  // ----------------------------------------
  // Pin synchronisers and 1 us tick
  // ----------------------------------------
  logic cq_meta_ff, cq_sync_ff, mode_meta_ff, serial_mode_ff;
  logic [5:0] div_ff;
  wire tick = (div_ff == 6'(`TICK_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cq_meta_ff <= 1'b0;
      cq_sync_ff <= 1'b0;
      mode_meta_ff <= 1'b0;
      serial_mode_ff <= 1'b0;
      div_ff <= 6'h00;
    end else begin
      cq_meta_ff <= cq_in;
      cq_sync_ff <= cq_meta_ff;
      mode_meta_ff <= serial_mode_pin;
      serial_mode_ff <= mode_meta_ff;
      div_ff <= tick ? 6'h00 : div_ff + 6'h01;
    end
  end

  // ----------------------------------------
  // Registers and bus decode
  // ----------------------------------------
  logic [3:0] ctrl_ff;
  logic [1:0] int_ff, mask_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [`ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  gen_state_t gen_st_ff, nxt_gen;
  wire gen_busy = (gen_st_ff != G_IDLE);
  wire do_wr = aw_ff && w_ff && !bvalid_ff;
  wire [3:0] wsel = reg_sel(awaddr_ff);
  wire [3:0] rsel = reg_sel(araddr);
  wire rd_take = arvalid && !rvalid_ff;
  wire wr_ctrl = do_wr && wsel[0];
  wire wr_int = do_wr && wsel[1];
  wire rd_int = rd_take && rsel[1];
  wire pending = |(int_ff & ~mask_ff);
  wire gen_start = wr_ctrl && wbyte_ff[`CTRL_REQ] && serial_mode_ff && !gen_busy;
  assign awready = !aw_ff && !bvalid_ff;
  assign wready = !w_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // Request bit reads as busy; it clears itself at sequence end
  wire [31:0] rd_mux = rsel[0] ? {28'h0000000, ctrl_ff[3:1], gen_busy} :
                       rsel[1] ? {30'h00000000, int_ff} :
                       rsel[2] ? {30'h00000000, mask_ff} :
                       {28'h0000000, cur_limit.wake_active, data_wake_pin_n, cq_sync_ff, serial_mode_ff};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= {awaddr[`ADDR_W-1:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_ff <= 1'b1;
        wbyte_ff <= wstrb[0] ? wdata[7:0] : 8'h00;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (|wsel) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= (|rsel) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wake detection
  // ----------------------------------------
  det_state_t det_st_ff, nxt_det;
  logic [8:0] det_cnt_ff;
  logic base_ff;
  wire returned = (cq_sync_ff == base_ff);
  wire det_hit = (det_st_ff == D_PULSE) && returned && !gen_busy &&
                 (det_cnt_ff >= `WU_MIN_US) &&
                 (det_cnt_ff <= `WU_MAX_US);
  always_comb begin
    nxt_det = det_st_ff;
    case (det_st_ff)
      D_WAIT: if (!returned && !gen_busy) nxt_det = D_PULSE;
      D_PULSE: begin
        if (returned) nxt_det = D_WAIT;
        else if (det_cnt_ff > `WU_MAX_US) nxt_det = D_LONG;
      end
      D_LONG: if (returned) nxt_det = D_WAIT;
      default: nxt_det = D_WAIT;
    endcase
  end
  // Our own generated pulse must not be taken for a remote wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_st_ff <= D_WAIT;
      det_cnt_ff <= 9'h000;
      base_ff <= 1'b0;
    end else begin
      det_st_ff <= gen_busy ? D_WAIT : nxt_det;
      if (gen_busy || det_st_ff == D_WAIT) base_ff <= gen_busy ? cq_sync_ff : base_ff;
      if (det_st_ff != D_PULSE) det_cnt_ff <= 9'h000;
      else if (tick) det_cnt_ff <= det_cnt_ff + 9'h001;
    end
  end

  // ----------------------------------------
  // Wake low timer and interrupt flags
  // ----------------------------------------
  logic wul_pin_ff, wul_irq_ff, irq_ff;
  logic [8:0] wul_cnt_ff;
  wire wul_end = tick && at_end(wul_cnt_ff, `WU_LOW_US);
  wire gen_done = (gen_st_ff == G_HIZ) && (nxt_gen == G_IDLE);
  wire [1:0] int_set = {gen_done, det_hit && serial_mode_ff};
  wire [1:0] int_clr = (wr_int ? wbyte_ff[1:0] : 2'h0) | {1'b0, rd_int};
  wire [1:0] nxt_int = (int_ff & ~int_clr) | int_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wul_pin_ff <= 1'b0;
      wul_irq_ff <= 1'b0;
      wul_cnt_ff <= 9'h000;
      int_ff <= 2'h0;
      mask_ff <= `MASK_RST;
      irq_ff <= 1'b0;
    end else begin
      if (det_hit) begin
        wul_pin_ff <= !serial_mode_ff;
        wul_irq_ff <= serial_mode_ff && mask_ff[`INT_WAKE] && !pending;
        wul_cnt_ff <= 9'h000;
      end else if (wul_end) begin
        wul_pin_ff <= 1'b0;
        wul_irq_ff <= 1'b0;
      end else if (tick && (wul_pin_ff || wul_irq_ff)) begin
        wul_cnt_ff <= wul_cnt_ff + 9'h001;
      end
      int_ff <= nxt_int;
      if (do_wr && wsel[2]) mask_ff <= wbyte_ff[1:0];
      irq_ff <= |(nxt_int & ~(do_wr && wsel[2] ? wbyte_ff[1:0] : mask_ff));
    end
  end
  assign data_wake_pin_n = !wul_pin_ff;
  assign wake_irq_pin_n = !(wul_irq_ff || irq_ff);
  assign irq = irq_ff;

  // ----------------------------------------
  // Wake generation
  // ----------------------------------------
  logic [8:0] gen_cnt_ff;
  logic orig_ff;
  cq_drive_t cq_ff, nxt_cq;
  cur_limit_t lim_ff;
  // On the start edge the latch is not loaded yet, so take the live level
  wire orig_lvl = gen_busy ? orig_ff : ctrl_ff[`CTRL_LVL];
  wire [8:0] gen_lim = (gen_st_ff == G_SETUP) ? `WU_SETUP_US :
                       (gen_st_ff == G_PULSE) ? `WU_PULSE_US :
                       (gen_st_ff == G_ON) ? `WU_ON_US : `WU_HIZ_US;
  wire step = tick && at_end(gen_cnt_ff, gen_lim);
  always_comb begin
    nxt_gen = gen_st_ff;
    case (gen_st_ff)
      G_IDLE: if (gen_start) nxt_gen = G_SETUP;
      G_SETUP: if (step) nxt_gen = G_PULSE;
      G_PULSE: if (step) nxt_gen = G_ON;
      G_ON: if (step) nxt_gen = G_HIZ;
      G_HIZ: if (step) nxt_gen = G_IDLE;
      default: nxt_gen = G_IDLE;
    endcase
  end
  always_comb begin
    case (nxt_gen)
      G_SETUP: nxt_cq = '{out: orig_lvl, oe: 1'b1};
      G_PULSE: nxt_cq = '{out: !orig_ff, oe: 1'b1};
      G_ON: nxt_cq = '{out: orig_ff, oe: 1'b1};
      G_HIZ: nxt_cq = '{out: orig_ff, oe: 1'b0};
      default: nxt_cq = '{out: ctrl_ff[`CTRL_LVL], oe: ctrl_ff[`CTRL_TXEN]};
    endcase
  end
  // Setup level is latched at start so register writes cannot disturb it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_st_ff <= G_IDLE;
      gen_cnt_ff <= 9'h000;
      orig_ff <= 1'b0;
      ctrl_ff <= `CTRL_RST;
      cq_ff <= '{out: 1'b0, oe: 1'b0};
      lim_ff <= '{wake_active: 1'b0, limit_off: 1'b0};
    end else begin
      gen_st_ff <= nxt_gen;
      if (nxt_gen != gen_st_ff) gen_cnt_ff <= 9'h000;
      else if (tick && gen_busy) gen_cnt_ff <= gen_cnt_ff + 9'h001;
      if (gen_start) orig_ff <= ctrl_ff[`CTRL_LVL];
      if (wr_ctrl) ctrl_ff <= {wbyte_ff[3:1], 1'b0};
      cq_ff <= (nxt_gen == G_IDLE && gen_st_ff == G_IDLE) ?
               '{out: ctrl_ff[`CTRL_LVL], oe: ctrl_ff[`CTRL_TXEN]} : nxt_cq;
      lim_ff <= '{wake_active: nxt_gen != G_IDLE,
                  limit_off: ctrl_ff[`CTRL_CURRENT_LIMIT_DISABLE] && nxt_gen == G_IDLE};
    end
  end
  assign cq_drive = cq_ff;
  assign cur_limit = lim_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_min_width;
    det_hit |-> det_cnt_ff >= 9'h042;
  endproperty
  a_min_width: assert property (p_min_width) else $error("short pulse accepted");
  property p_max_width;
    (det_st_ff == D_PULSE && det_cnt_ff > 9'h05f) |-> !det_hit ##1 det_st_ff != D_WAIT || returned;
  endproperty
  a_max_width: assert property (p_max_width) else $error("long pulse accepted");
  property p_low_time;
    $fell(wul_pin_ff || wul_irq_ff) |-> $past(wul_cnt_ff) == 9'h0c7 && $past(tick);
  endproperty
  a_low_time: assert property (p_low_time) else $error("wake low time wrong");
  property p_setup;
    $rose(gen_st_ff == G_SETUP) |-> serial_mode_ff && cq_ff.oe && cq_ff.out == orig_ff;
  endproperty
  a_setup: assert property (p_setup) else $error("setup drive wrong");
  property p_pulse;
    (gen_st_ff == G_PULSE && $past(gen_st_ff) == G_SETUP) |->
      $past(gen_cnt_ff) == 9'h04f ##0 cq_ff.out != orig_ff;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse start wrong");
  property p_on;
    $rose(gen_st_ff == G_ON) |-> $past(gen_cnt_ff) == 9'h054 && cq_ff.oe && cq_ff.out == orig_ff;
  endproperty
  a_on: assert property (p_on) else $error("on-time drive wrong");
  property p_hiz;
    $rose(gen_st_ff == G_HIZ) |-> !cq_ff.oe throughout (gen_st_ff == G_HIZ)[*8];
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver not released");
  property p_limit;
    gen_busy |-> cur_limit.wake_active && !cur_limit.limit_off;
  endproperty
  a_limit: assert property (p_limit) else $error("wake current limit lost");
  property p_pin_mode;
    (det_hit && !serial_mode_ff) |=> !data_wake_pin_n;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("data wake pin idle");
  property p_irq_pulse;
    (det_hit && serial_mode_ff && mask_ff[0] && !pending) |=> !wake_irq_pin_n && data_wake_pin_n;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pin pulse missing");
  property p_irq_hold;
    (det_hit && serial_mode_ff && !mask_ff[0] && !(do_wr && wsel[2])) |=> ##1 int_ff[0] && !wake_irq_pin_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("wake flag not held");
  property p_start;
    gen_start |=> gen_st_ff == G_SETUP && gen_cnt_ff == 9'h000;
  endproperty
  a_start: assert property (p_start) else $error("sequence did not start");
endmodule

// ===== sim/line_master.sv
// Purpose: Line master model on the C/Q wire
// Assumes: Master idles low and sends high wake pulses
// Notes: Device driver owns the wire while its enable is high
`timescale 1ns/10ps
module line_master import wake_pkg::*; (
  // Clock
  input wire logic aclk,
  // Wire
  input wire cq_drive_t cq_drive,
  output logic cq_in
);
  logic lvl_ff;
  initial lvl_ff = 1'b0;
  // Both ends see one resolved level
  assign cq_in = cq_drive.oe ? cq_drive.out : lvl_ff;
  task automatic pulse(input int us);
    @(posedge aclk);
    lvl_ff <= 1'b1;
    repeat (us * 50) @(posedge aclk);
    lvl_ff <= 1'b0;
  endtask
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for wake detection and generation
// Assumes: 50 MHz clock, registers over AXI4-Lite
// Notes: Phase widths checked with one tick of slack for the free divider
`timescale 1ns/10ps
`include "wake_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb import wake_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, serial_mode_pin;
  logic awready, wready, bvalid, arready, rvalid, cq_in, data_wake_pin_n, wake_irq_pin_n, irq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  cq_drive_t cq_drive;
  cur_limit_t cur_limit;
  int failures, comparisons, n;
  cq_wakeup_detect_generate dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .cq_in(cq_in), .serial_mode_pin(serial_mode_pin),
    .cq_drive(cq_drive), .cur_limit(cur_limit), .data_wake_pin_n(data_wake_pin_n),
    .wake_irq_pin_n(wake_irq_pin_n), .irq(irq));
  line_master u_master (.aclk(aclk), .cq_drive(cq_drive), .cq_in(cq_in));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tmo(input int k);
    if (k >= 50) begin
      failures++;
      $display("[ERR] bus answer exp 1 got 0");
      test_done;
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    tmo(k);
  endtask
  task automatic axi_rd(input logic [4:0] a);
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    tmo(k);
  endtask
  function automatic logic pin(input bit s);
    return s ? wake_irq_pin_n : data_wake_pin_n;
  endfunction
  // Cycles a wake output stays low, zero if it never falls
  task automatic low_time(input bit s);
    int k;
    n = 0;
    for (k = 0; k < 400 && pin(s) !== 1'b0; k++) @(posedge aclk);
    while (pin(s) === 1'b0 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic phase(input logic [1:0] m, input logic [1:0] v);
    n = 0;
    while ((cq_drive & m) === v && n < 30000) begin
      @(posedge aclk);
      n++;
    end
  endtask
  function automatic logic inr(input int c, input int us);
    return c >= (us - 1) * `TICK_CYC && c <= us * `TICK_CYC + 1;
  endfunction
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    failures = 0; comparisons = 0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 5'h00; araddr = 5'h00; wdata = 32'h0; wstrb = 4'h0; serial_mode_pin = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(`OFS_MASK);
    `CHK("mask_rst", 32'h1, d)
    axi_rd(5'h10);
    `CHK("unmapped", `RESP_SLVERR, r)
    axi_wr(`OFS_CTRL, 32'h1);
    `CHK("wr_resp", `RESP_OKAY, r)
    repeat (5) @(posedge aclk);
    `CHK("pin_mode_req", 2'b00, cq_drive)
    u_master.pulse(60);
    repeat (300) @(posedge aclk);
    `CHK("short_pulse", 1'b1, data_wake_pin_n)
    u_master.pulse(100);
    repeat (300) @(posedge aclk);
    `CHK("long_pulse", 1'b1, data_wake_pin_n)
    u_master.pulse(80);
    low_time(1'b0);
    `CHK("pin_low_time", 1'b1, n >= 7500 && n <= 12500)
    serial_mode_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    u_master.pulse(80);
    low_time(1'b1);
    `CHK("irq_pin_low_time", 1'b1, n >= 7500 && n <= 12500)
    `CHK("irq_masked", 1'b0, irq)
    // Clear the flag left by the masked wake so the next check sees only the new one
    axi_rd(`OFS_INT);
    `CHK("masked_flag", 2'h1, d[1:0])
    axi_wr(`OFS_MASK, 32'h0);
    `CHK("irq_pin_idle", 1'b1, wake_irq_pin_n)
    u_master.pulse(80);
    repeat (15300) @(posedge aclk);
    `CHK("irq_pin_held", 1'b0, wake_irq_pin_n)
    `CHK("irq_level", 1'b1, irq)
    axi_rd(`OFS_INT);
    `CHK("wake_flag", 1'b1, d[0])
    repeat (3) @(posedge aclk);
    `CHK("irq_pin_freed", 1'b1, wake_irq_pin_n)
    // Wake bit masked so only the done event can raise irq
    axi_wr(`OFS_MASK, 32'h1);
    // Drive the line high first so the setup phase holds a driven level
    axi_wr(`OFS_CTRL, 32'he);
    repeat (4) @(posedge aclk);
    `CHK("idle_limit", 2'b01, cur_limit)
    axi_rd(`OFS_STAT);
    `CHK("stat", 32'h7, d)
    axi_wr(`OFS_CTRL, 32'hf);
    `CHK("wake_limit", 2'b10, cur_limit)
    phase(2'b11, 2'b11);
    `CHK("setup_time", 1'b1, inr(n, `WU_SETUP_US))
    phase(2'b11, 2'b01);
    `CHK("pulse_time", 1'b1, inr(n, `WU_PULSE_US))
    phase(2'b11, 2'b11);
    `CHK("on_time", 1'b1, inr(n, `WU_ON_US))
    phase(2'b01, 2'b00);
    `CHK("hiz_time", 1'b1, inr(n, `WU_HIZ_US))
    repeat (5) @(posedge aclk);
    `CHK("idle_drive", 2'b11, cq_drive)
    `CHK("done_irq", 1'b1, irq)
    axi_rd(`OFS_INT);
    `CHK("done_flag", 1'b1, d[1])
    test_done;
  end
endmodule
